// ### logic/lpx_link_exit.sv
// U1/U2/U3 exit and Recovery.Active control for one link port
`timescale 1ns/1ps
`default_nettype none

// Operation
// - downstream U1: ping timer reaching 300 ms sends port to Rx.Detect
// - downstream in U1/U2/U3 goes to disabled when higher control directs
// - warm reset issued (downstream) or detected (upstream) leads to Rx.Detect
// - self-powered upstream port losing bus supply goes to disabled
// - U1 moves to U2 when the U2 inactivity timer expires
// - U1 enters Recovery after a successful U1 exit handshake
// - U1/U2 handshake timer of 2 ms expiring unanswered gives inactive
// - downstream U2 ignores ping LFPS; only exit signalling starts an exit
// - exit detect on in U2, wakeup detect in U3, config lane only
// - self-started exits enable the LFPS transmitter on the config lane
// - downstream U2 repeats far-end termination detection every 100 ms
// - downstream U2/U3 goes to Rx.Detect on high-impedance far end
// - U2 enters Recovery after a successful U2 exit handshake
// - ping LFPS detection is off while in U3
// - downstream U3 repeats far-end termination detection every 100 ms
// - U3 enters Recovery after a successful wakeup handshake
// - U3 wake fail after 10 ms stays in U3, retries 100 ms later
// - a port late to answer a wakeup may start its own wakeup
// - Recovery.Active starts a 12 ms timer running until all lanes exit
// - Recovery.Active sends TS1 on every lane until the port advances
// - receiver trains on TS1/TS2 and each lane's handshake is watched
// - Gen 2 inserts one SYNC after every 32 TS1 sets
// - U1 ping timer restarts on each received ping LFPS
// - eight identical TS1/TS2 on every active lane move to Recovery.Configuration
// - 12 ms or exit timer expiry gives inactive, or Rx.Detect on downstream hot reset
module lpx_link_exit
   import lpx_pkg::*;
#(
   parameter int CLK_KHZ = LPX_CLK_KHZ,
   parameter int LANES = 2,
   parameter int PING_CYC = LPX_PING_TIMEOUT_MS * CLK_KHZ,
   parameter int RESP_U12_CYC = LPX_LFPS_RESP_U12_MS * CLK_KHZ,
   parameter int RESP_U3_CYC = LPX_LFPS_RESP_U3_MS * CLK_KHZ,
   parameter int RXDET_CYC = LPX_RXDET_PERIOD_MS * CLK_KHZ,
   parameter int RETRY_CYC = LPX_WAKE_RETRY_MS * CLK_KHZ,
   parameter int REC_CYC = LPX_REC_ACTIVE_MS * CLK_KHZ
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic is_downstream,
   input wire logic self_powered,
   input wire logic gen2,
   input wire logic enter_u1,
   input wire logic enter_u2,
   input wire logic enter_u3,
   input wire logic enter_recovery,
   input wire logic hot_reset_attempt,
   input wire logic disable_req,
   input wire logic warm_reset_req,
   input wire logic warm_reset_seen,
   input wire logic vbus_valid,
   input wire logic u2_inact_expired,
   input wire logic local_exit_req,
   input wire logic ping_lfps_seen,
   input wire logic exit_lfps_seen,
   input wire logic handshake_ok,
   input wire logic ux_exit_timeout,
   input wire logic rxdet_done,
   input wire logic rxdet_high_imp,
   input wire logic [LANES-1:0] lane_active,
   input wire logic [LANES-1:0] ts_rx_valid,
   input wire logic [LANES-1:0] ts_rx_same,
   input wire logic ts_tx_done,
   output logic [2:0] link_state,
   output logic [2:0] exit_code,
   output logic exit_valid,
   output logic lfps_tx_en,
   output logic exit_detect_en,
   output logic wake_detect_en,
   output logic ping_detect_en,
   output logic rxdet_start,
   output logic ts1_tx_en,
   output logic sync_tx_req,
   output logic rx_train_en
);
   if (LANES < 1 || LANES > 2 || CLK_KHZ < 1 || REC_CYC < 2
      || PING_CYC > 2 ** LPX_CNT_W || RXDET_CYC > 2 ** LPX_CNT_W)
   begin
      $error("lpx_link_exit: unsupported parameters");
   end

   localparam logic [LPX_CNT_W-1:0] PING_T = LPX_CNT_W'(PING_CYC - 1);
   localparam logic [LPX_CNT_W-1:0] R12_T = LPX_CNT_W'(RESP_U12_CYC - 1);
   localparam logic [LPX_CNT_W-1:0] R3_T = LPX_CNT_W'(RESP_U3_CYC - 1);
   localparam logic [LPX_CNT_W-1:0] RXD_T = LPX_CNT_W'(RXDET_CYC - 1);
   localparam logic [LPX_CNT_W-1:0] RTY_T = LPX_CNT_W'(RETRY_CYC - 1);
   localparam logic [LPX_CNT_W-1:0] REC_T = LPX_CNT_W'(REC_CYC - 1);
   localparam logic [3:0] MATCH_T = 4'(LPX_TS_MATCH_NEED);
   localparam logic [4:0] SYNC_T = 5'(LPX_TS1_PER_SYNC - 1);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers for the asynchronous pin-level indications
   logic [1:0] vbus_sync;
   logic [1:0] warm_sync;
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         vbus_sync <= 2'h0;
         warm_sync <= 2'h0;
      end
      else
      begin
         vbus_sync <= {vbus_sync[0], vbus_valid};
         warm_sync <= {warm_sync[0], warm_reset_seen};
      end
   end
   wire vbus_ok = vbus_sync[1];
   wire warm_seen = warm_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // state and timers
   lpx_state_t state;
   lpx_state_t next_state;
   lpx_exit_t next_exit;
   logic [LPX_CNT_W-1:0] ping_cnt;
   logic [LPX_CNT_W-1:0] resp_cnt;
   logic [LPX_CNT_W-1:0] rxdet_cnt;
   logic [LPX_CNT_W-1:0] retry_cnt;
   logic [LPX_CNT_W-1:0] rec_cnt;
   logic hs_busy;
   logic retry_wait;
   logic [3:0] match_cnt [LANES];
   logic [4:0] ts1_cnt;

   wire in_u1 = (state == LPX_ST_U1);
   wire in_u2 = (state == LPX_ST_U2);
   wire in_u3 = (state == LPX_ST_U3);
   wire in_ux = in_u1 || in_u2 || in_u3;
   wire in_rec = (state == LPX_ST_REC_ACT);

   // U2 ping bursts never count as an exit; the detector only flags exit
   // signalling, pings are consumed by the U1 ping timer alone
   wire exit_seen = (in_u1 || in_u2) && exit_lfps_seen;
   wire start_local = in_ux && local_exit_req && !hs_busy && !retry_wait;
   wire resp_lim = in_u3 ? (resp_cnt == R3_T) : (resp_cnt == R12_T);
   wire resp_expired = hs_busy && resp_lim && !handshake_ok;
   wire ping_expired = in_u1 && is_downstream && (ping_cnt == PING_T);
   wire rxdet_due = (in_u2 || in_u3) && is_downstream && (rxdet_cnt == RXD_T);
   wire far_gone = (in_u2 || in_u3) && is_downstream && rxdet_done
      && rxdet_high_imp;
   wire dir_disable = (in_ux || in_rec) && is_downstream && disable_req;
   wire warm = (in_ux || in_rec) && (is_downstream ? warm_reset_req
      : warm_seen);
   wire vbus_lost = in_ux && !is_downstream && self_powered && !vbus_ok;
   wire rec_expired = in_rec && ((rec_cnt == REC_T) || ux_exit_timeout);

   logic [LANES-1:0] lane_done;
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         assign lane_done[g] = !lane_active[g] || (match_cnt[g] >= MATCH_T);
         always_ff @(posedge clk_sys)
         begin
            if (!rstn || !in_rec)
               match_cnt[g] <= 4'h0;
            else if (ts_rx_valid[g] && match_cnt[g] < MATCH_T)
               match_cnt[g] <= ts_rx_same[g] ? match_cnt[g] + 4'h1 : 4'h1;
         end
      end
   endgenerate
   wire all_lanes = &lane_done;

   always_comb
   begin
      next_state = state;
      next_exit = LPX_EX_NONE;
      if (warm)
         next_exit = LPX_EX_RXDET;
      else if (dir_disable)
         next_exit = LPX_EX_DISABLED;
      else if (vbus_lost)
         next_exit = LPX_EX_DISABLED;
      else if (ping_expired || far_gone)
         next_exit = LPX_EX_RXDET;
      else if (rec_expired)
         next_exit = (is_downstream && hot_reset_attempt) ? LPX_EX_RXDET
            : LPX_EX_INACTIVE;
      else if (in_rec && all_lanes)
         next_exit = LPX_EX_REC_CFG;
      else if (in_ux && handshake_ok && (hs_busy || exit_seen || in_u3))
         next_state = LPX_ST_REC_ACT;
      else if (resp_expired && !in_u3)
         next_exit = LPX_EX_INACTIVE;
      else if (in_u1 && u2_inact_expired)
         next_state = LPX_ST_U2;
      if (next_exit != LPX_EX_NONE)
         next_state = LPX_ST_IDLE;
      if (state == LPX_ST_IDLE || next_exit != LPX_EX_NONE)
      begin
         if (enter_u1)
            next_state = LPX_ST_U1;
         else if (enter_u2)
            next_state = LPX_ST_U2;
         else if (enter_u3)
            next_state = LPX_ST_U3;
         else if (enter_recovery)
            next_state = LPX_ST_REC_ACT;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         state <= LPX_ST_IDLE;
      else
         state <= next_state;
   end

   // ping timer cleared and restarted on every ping
   always_ff @(posedge clk_sys)
   begin
      if (!rstn || !in_u1 || ping_lfps_seen || next_state != LPX_ST_U1)
         ping_cnt <= '0;
      else if (ping_cnt != PING_T)
         ping_cnt <= ping_cnt + 1'b1;
   end

   // handshake response window, 2 ms in U1/U2, 10 ms in U3
   always_ff @(posedge clk_sys)
   begin
      if (!rstn || !in_ux || next_state != state)
      begin
         hs_busy <= 1'b0;
         resp_cnt <= '0;
      end
      else if (!hs_busy && (start_local || exit_seen))
      begin
         hs_busy <= 1'b1;
         resp_cnt <= '0;
      end
      else if (hs_busy)
      begin
         hs_busy <= !resp_lim;
         resp_cnt <= resp_cnt + 1'b1;
      end
   end

   // failed U3 wake holds off 100 ms, then retries while still wanted;
   // a late responder may start its own wakeup from here too
   always_ff @(posedge clk_sys)
   begin
      if (!rstn || !in_u3)
      begin
         retry_wait <= 1'b0;
         retry_cnt <= '0;
      end
      else if (in_u3 && resp_expired)
      begin
         retry_wait <= 1'b1;
         retry_cnt <= '0;
      end
      else if (retry_wait)
      begin
         retry_wait <= (retry_cnt != RTY_T);
         retry_cnt <= retry_cnt + 1'b1;
      end
   end

   // periodic far-end termination detection
   always_ff @(posedge clk_sys)
   begin
      if (!rstn || rxdet_due || !(in_u2 || in_u3))
         rxdet_cnt <= '0;
      else
         rxdet_cnt <= rxdet_cnt + 1'b1;
   end

   // runs from entry until every lane is through
   always_ff @(posedge clk_sys)
   begin
      if (!rstn || !in_rec)
         rec_cnt <= '0;
      else if (rec_cnt != REC_T)
         rec_cnt <= rec_cnt + 1'b1;
   end

   // sync after every 32 TS1 in Gen 2
   always_ff @(posedge clk_sys)
   begin
      if (!rstn || !in_rec)
         ts1_cnt <= 5'h0;
      else if (ts_tx_done)
         ts1_cnt <= ts1_cnt + 5'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         link_state <= LPX_ST_IDLE;
         exit_code <= LPX_EX_NONE;
         exit_valid <= 1'b0;
         lfps_tx_en <= 1'b0;
         exit_detect_en <= 1'b0;
         wake_detect_en <= 1'b0;
         ping_detect_en <= 1'b0;
         rxdet_start <= 1'b0;
         ts1_tx_en <= 1'b0;
         sync_tx_req <= 1'b0;
         rx_train_en <= 1'b0;
      end
      else
      begin
         link_state <= next_state;
         exit_code <= next_exit;
         exit_valid <= (next_exit != LPX_EX_NONE);
         lfps_tx_en <= start_local || (lfps_tx_en && hs_busy && in_ux);
         exit_detect_en <= (next_state == LPX_ST_U1)
            || (next_state == LPX_ST_U2);
         wake_detect_en <= (next_state == LPX_ST_U3);
         ping_detect_en <= is_downstream
            && (next_state == LPX_ST_U1);
         rxdet_start <= rxdet_due;
         ts1_tx_en <= (next_state == LPX_ST_REC_ACT);
         sync_tx_req <= gen2 && in_rec && ts_tx_done
            && (ts1_cnt == SYNC_T);
         rx_train_en <= (next_state == LPX_ST_REC_ACT);
      end
   end
endmodule

`default_nettype wire

// ### logic/lpx_pkg.sv
// constants and types shared by the low-power exit and recovery block
package lpx_pkg;
   localparam int LPX_CLK_KHZ = 200000;
   // times in their printed units, then counts and the counter width
   localparam int LPX_PING_TIMEOUT_MS = 300;
   localparam int LPX_LFPS_RESP_U12_MS = 2;
   localparam int LPX_LFPS_RESP_U3_MS = 10;
   localparam int LPX_RXDET_PERIOD_MS = 100;
   localparam int LPX_WAKE_RETRY_MS = 100;
   localparam int LPX_REC_ACTIVE_MS = 12;
   localparam int LPX_TS1_PER_SYNC = 32;
   localparam int LPX_TS_MATCH_NEED = 8;
   localparam int LPX_CNT_W = 27;

   typedef enum logic [2:0]
   {
      LPX_ST_U1 = 3'b000,
      LPX_ST_U2 = 3'b001,
      LPX_ST_U3 = 3'b010,
      LPX_ST_REC_ACT = 3'b011,
      LPX_ST_IDLE = 3'b100
   } lpx_state_t;

   typedef enum logic [2:0]
   {
      LPX_EX_NONE = 3'b000,
      LPX_EX_RXDET = 3'b001,
      LPX_EX_DISABLED = 3'b010,
      LPX_EX_INACTIVE = 3'b011,
      LPX_EX_U2 = 3'b100,
      LPX_EX_REC_CFG = 3'b101
   } lpx_exit_t;
endpackage

// ### tb/lpx_link_exit_assertions.sv
// checker for exit and recovery behaviour at the block's ports
`timescale 1ns/1ps
`default_nettype none
module lpx_link_exit_chk
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic is_downstream,
   input wire logic disable_req,
   input wire logic warm_reset_req,
   input wire logic u2_inact_expired,
   input wire logic local_exit_req,
   input wire logic hot_reset_attempt,
   input wire logic gen2,
   input wire logic [2:0] link_state,
   input wire logic [2:0] exit_code,
   input wire logic exit_valid,
   input wire logic lfps_tx_en,
   input wire logic exit_detect_en,
   input wire logic wake_detect_en,
   input wire logic ping_detect_en,
   input wire logic rxdet_start,
   input wire logic ts1_tx_en,
   input wire logic sync_tx_req,
   input wire logic rx_train_en
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wire logic ux = link_state < 3'h3;
   ////////////////////////////////////////
   property p_warm;
      warm_reset_req && is_downstream && ux |=> exit_valid && exit_code == 3'h1;
   endproperty
   a_warm: assert property (p_warm) else $error("warm exit wrong");
   property p_dis;
      disable_req && is_downstream && !warm_reset_req && ux
         |=> exit_valid && exit_code == 3'h2;
   endproperty
   a_dis: assert property (p_dis) else $error("disable exit wrong");
   property p_u1u2;
      link_state == 3'h0 && u2_inact_expired |=> link_state == 3'h1 || exit_valid;
   endproperty
   a_u1u2: assert property (p_u1u2) else $error("no move to U2");
   property p_u3det;
      link_state == 3'h2 |-> !ping_detect_en && wake_detect_en;
   endproperty
   a_u3det: assert property (p_u3det) else $error("U3 detect wrong");
   property p_u2det;
      link_state == 3'h1 |-> exit_detect_en;
   endproperty
   a_u2det: assert property (p_u2det) else $error("U2 detect off");
   property p_lfps;
      $rose(lfps_tx_en) |-> ux && $past(local_exit_req);
   endproperty
   a_lfps: assert property (p_lfps) else $error("lfps without cause");
   property p_rec;
      link_state == 3'h3 |-> ts1_tx_en && rx_train_en;
   endproperty
   a_rec: assert property (p_rec) else $error("training off");
   property p_rxdet;
      rxdet_start |-> $past(is_downstream)
         && ($past(link_state) == 3'h1 || $past(link_state) == 3'h2);
   endproperty
   a_rxdet: assert property (p_rxdet) else $error("stray detect");
   property p_hot;
      exit_valid && $past(link_state) == 3'h3 && $past(hot_reset_attempt)
         && is_downstream |-> exit_code != 3'h3;
   endproperty
   a_hot: assert property (p_hot) else $error("hot reset exit wrong");
   property p_cfg;
      exit_valid && exit_code == 3'h5 |-> $past(link_state) == 3'h3;
   endproperty
   a_cfg: assert property (p_cfg) else $error("config exit wrong");
   property p_sync;
      sync_tx_req |-> $past(gen2) && $past(ts1_tx_en);
   endproperty
   a_sync: assert property (p_sync) else $error("stray sync");
   c_cfg: cover property (exit_valid && exit_code == 3'h5);
   c_u2: cover property (link_state == 3'h1);
   c_sync: cover property (sync_tx_req);
endmodule
bind lpx_link_exit lpx_link_exit_chk i_chk (.clk_sys, .rstn, .is_downstream,
   .disable_req, .warm_reset_req, .u2_inact_expired, .local_exit_req,
   .hot_reset_attempt, .gen2, .link_state, .exit_code, .exit_valid, .lfps_tx_en,
   .exit_detect_en, .wake_detect_en, .ping_detect_en, .rxdet_start, .ts1_tx_en,
   .sync_tx_req, .rx_train_en);
`default_nettype wire

// ### tb/lpx_peer.sv
// peer link layer model: answers exit signalling, sends training sets
`timescale 1ns/1ps
`default_nettype none
module lpx_peer
#(
   parameter int LANES = 2
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic lfps_tx_en,
   input wire logic ts1_tx_en,
   input wire logic mute,
   input wire logic [LANES-1:0] lanes,
   input wire logic [7:0] dly,
   output logic handshake_ok,
   output logic [LANES-1:0] ts_rx_valid,
   output logic [LANES-1:0] ts_rx_same,
   output logic ts_tx_done
);
   logic [7:0] hc;
   logic [2:0] tc;
   wire logic ts_due = ts1_tx_en && tc == 3'h5;
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         hc <= 8'h00;
         tc <= 3'h0;
         handshake_ok <= 1'b0;
         ts_rx_valid <= '0;
         ts_rx_same <= '0;
         ts_tx_done <= 1'b0;
      end
      else
      begin
         // a late answer is legal; dly stays well inside the timer
         hc <= lfps_tx_en ? hc + 8'h01 : 8'h00;
         handshake_ok <= lfps_tx_en && !mute && hc == dly;
         tc <= (!ts1_tx_en || ts_due) ? 3'h0 : tc + 3'h1;
         ts_rx_valid <= {LANES{ts_due && !mute}} & lanes;
         // between sets the compare flag wanders so it is never trusted
         ts_rx_same <= ts_due ? '1 : ~ts_rx_same;
         ts_tx_done <= ts1_tx_en;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the low-power exit and recovery block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lpx_pkg::*;
   logic clk_sys = 1'b0, rstn = 1'b0, is_downstream = 1'b1, gen2 = 1'b0;
   logic self_powered = 1'b0, enter_u1 = 1'b0, enter_u2 = 1'b0, mute = 1'b0;
   logic enter_u3 = 1'b0, enter_recovery = 1'b0, hot_reset_attempt = 1'b0;
   logic disable_req = 1'b0, warm_reset_req = 1'b0, vbus_valid = 1'b1;
   logic u2_inact_expired = 1'b0, local_exit_req = 1'b0, rxdet_done = 1'b0;
   logic ping_lfps_seen = 1'b0, exit_lfps_seen = 1'b0, rxdet_high_imp = 1'b0;
   logic [7:0] dly = 8'h01;
   logic warm_reset_seen = 1'b0, ux_exit_timeout = 1'b0;
   logic [1:0] lane_active = 2'b11;
   logic handshake_ok, ts_tx_done, exit_valid, lfps_tx_en, exit_detect_en;
   logic wake_detect_en, ping_detect_en, rxdet_start, ts1_tx_en, sync_tx_req;
   logic rx_train_en;
   logic [1:0] ts_rx_valid, ts_rx_same;
   logic [2:0] link_state, exit_code;
   logic [2:0] q[$];
   int failures = 0, total_checks = 0, seed = 91, cyc = 0, nd = 0, ns = 0, n;
   lpx_link_exit #(.PING_CYC(100), .RESP_U12_CYC(30), .RESP_U3_CYC(40),
      .RXDET_CYC(60), .RETRY_CYC(80), .REC_CYC(150)) i_dut (.clk_sys, .rstn,
      .is_downstream, .self_powered, .gen2, .enter_u1, .enter_u2, .enter_u3,
      .enter_recovery, .hot_reset_attempt, .disable_req, .warm_reset_req,
      .warm_reset_seen, .vbus_valid, .u2_inact_expired, .local_exit_req,
      .ping_lfps_seen, .exit_lfps_seen, .handshake_ok, .ux_exit_timeout,
      .rxdet_done, .rxdet_high_imp, .lane_active, .ts_rx_valid,
      .ts_rx_same, .ts_tx_done, .link_state, .exit_code, .exit_valid,
      .lfps_tx_en, .exit_detect_en, .wake_detect_en, .ping_detect_en,
      .rxdet_start, .ts1_tx_en, .sync_tx_req, .rx_train_en);
   lpx_peer #(.LANES(2)) i_peer (.clk_sys, .rstn, .lfps_tx_en, .ts1_tx_en,
      .mute, .lanes(lane_active), .dly, .handshake_ok, .ts_rx_valid,
      .ts_rx_same, .ts_tx_done);
   always #2.5 clk_sys = ~clk_sys;
   ////////////////////////////////////////
   task automatic wrap_up;
      if (q.size() != 0)
         failures++;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [2:0] e, input logic [2:0] a);
      total_checks++;
      if (a !== e)
      begin
         failures++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask
   task automatic chk_n(input int e, input int a);
      total_checks++;
      if (a != e)
      begin
         failures++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask
   // enter state k and note the exit that must follow
   task automatic go(input int k, input logic [2:0] e);
      q.push_back(e);
      {enter_recovery, enter_u3, enter_u2, enter_u1} = 4'h1 << k;
      @(negedge clk_sys);
      {enter_recovery, enter_u3, enter_u2, enter_u1} = 4'h0;
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask
   // bounded wait for an exit pulse, or for a detection start if d is set
   task automatic wt(input bit d, output int c);
      c = 0;
      do
      begin
         @(posedge clk_sys);
         c++;
      end
      while (c < 600 && (d ? rxdet_start : exit_valid) !== 1'b1);
      if (c >= 600)
      begin
         failures++;
         $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
      end
      @(negedge clk_sys);
   endtask
   always @(posedge clk_sys)
   begin
      if (ts1_tx_en === 1'b1 && ts_tx_done === 1'b1)
         nd++;
      if (sync_tx_req === 1'b1)
         ns++;
      if (exit_valid === 1'b1)
         chk(q.size() > 0 ? q.pop_front() : 3'h0, exit_code);
   end
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         wrap_up();
      end
   end
   ////////////////////////////////////////
   initial
   begin
      repeat (4) @(negedge clk_sys);
      rstn = 1'b1;
      repeat (3) @(negedge clk_sys);
      for (int g = 0; g < 2; g++)
      begin
         gen2 = g[0];
         // second pass leaves lane 1 unnegotiated and silent
         lane_active = {~g[0], 1'b1};
         dly = 8'h01 + (8'($random(seed)) & 8'h0f);
         nd = 0;
         ns = 0;
         go(0, LPX_EX_REC_CFG);
         local_exit_req = 1'b1;
         wt(0, n);
         local_exit_req = 1'b0;
         chk_n(g * (nd / LPX_TS1_PER_SYNC), ns);
      end
      lane_active = 2'b11;
      go(0, LPX_EX_RXDET);
      repeat (3)
      begin
         repeat (50 + ($random(seed) & 8'h1f)) @(negedge clk_sys);
         pulse(ping_lfps_seen);
      end
      wt(0, n);
      chk_n(1, int'(n >= 95 && n <= 106));
      for (int k = 0; k < 3; k++)
      begin
         go(k, LPX_EX_DISABLED);
         pulse(disable_req);
         wt(0, n);
         go(k, LPX_EX_RXDET);
         pulse(warm_reset_req);
         wt(0, n);
      end
      is_downstream = 1'b0;
      self_powered = 1'b1;
      go(1, LPX_EX_DISABLED);
      vbus_valid = 1'b0;
      wt(0, n);
      vbus_valid = 1'b1;
      repeat (4) @(negedge clk_sys);
      go(2, LPX_EX_RXDET);
      warm_reset_seen = 1'b1;
      wt(0, n);
      warm_reset_seen = 1'b0;
      chk_n(1, int'(n >= 3 && n <= 5));
      is_downstream = 1'b1;
      repeat (4) @(negedge clk_sys);
      go(0, LPX_EX_RXDET);
      pulse(u2_inact_expired);
      @(negedge clk_sys);
      chk(LPX_ST_U2, link_state);
      pulse(ping_lfps_seen);
      chk(LPX_ST_U2, link_state);
      wt(1, n);
      pulse(rxdet_done);
      wt(1, n);
      chk_n(1, int'(n >= 54 && n <= 64));
      rxdet_high_imp = 1'b1;
      pulse(rxdet_done);
      wt(0, n);
      rxdet_high_imp = 1'b0;
      mute = 1'b1;
      go(1, LPX_EX_INACTIVE);
      pulse(exit_lfps_seen);
      wt(0, n);
      chk_n(1, int'(n >= 28 && n <= 36));
      go(1, LPX_EX_INACTIVE);
      local_exit_req = 1'b1;
      wt(0, n);
      chk_n(1, int'(n >= 28 && n <= 36));
      go(2, LPX_EX_REC_CFG);
      repeat (50) @(negedge clk_sys);
      chk(LPX_ST_U3, link_state);
      mute = 1'b0;
      repeat (60) @(negedge clk_sys);
      chk(LPX_ST_U3, link_state);
      wt(0, n);
      local_exit_req = 1'b0;
      mute = 1'b1;
      for (int h = 0; h < 3; h++)
      begin
         hot_reset_attempt = h[0];
         go(3, h[0] ? LPX_EX_RXDET : LPX_EX_INACTIVE);
         if (h == 2)
            pulse(ux_exit_timeout);
         wt(0, n);
         chk_n(1, int'(h == 2 ? n <= 2 : n >= 146 && n <= 156));
      end
      wrap_up();
   end
endmodule
`default_nettype wire
